// [dci_core.v]
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dci_defs.vh"

module dci_core (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        srst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Request pins
  input  wire        maskable_request_n,
  input  wire        nonmaskable_request_n,
  input  wire        bus_request_n,
  // Bus cycle outputs and read data input
  output reg         opcode_fetch_cycle_n,
  output reg         memory_request_n,
  output reg         io_request_n,
  output reg         read_strobe_n,
  output reg  [15:0] address,
  output reg  [7:0]  data_out,
  output reg         data_out_en_n,
  input  wire [7:0]  data_in,
  // Status
  output reg         halted,
  output reg         int_enable,
  output reg  [1:0]  int_mode
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_HALT  = 4'h1;
  localparam [3:0] ST_ACK   = 4'h2;
  localparam [3:0] ST_M0RD  = 4'h3;
  localparam [3:0] ST_PUSHH = 4'h4;
  localparam [3:0] ST_PUSHL = 4'h5;
  localparam [3:0] ST_TBL0  = 4'h6;
  localparam [3:0] ST_TBL1  = 4'h7;
  localparam [3:0] ST_RETI0 = 4'h8;
  localparam [3:0] ST_RETI1 = 4'h9;
  localparam [3:0] ST_NMI   = 4'ha;

  reg [3:0]  state;
  reg [2:0]  tcnt;
  reg [7:0]  acc;
  reg [7:0]  vector_base_reg;
  reg [15:0] pc;
  reg [15:0] sp;
  reg [15:0] table_ptr;
  reg [7:0]  fetched;
  reg [7:0]  extra_bytes;
  reg        iff_save;
  reg        nmi_seen;
  reg        ret_req;
  reg        return_from_interrupt_op_req;
  reg        use_table;
  reg [2:0]  int_sync;
  reg [2:0]  nmi_sync;
  reg [2:0]  brq_sync;
  reg        int_q;
  reg        nmi_q;
  reg        brq_q;
  reg        nmi_prev;

  wire apb_wr = psel & penable & pwrite;
  wire cmd_wr = apb_wr & (paddr == `DCI_OFF_CMD);
  wire nmi_edge = nmi_q & ~nmi_prev;
  wire last_t = (tcnt == `DCI_T_STATES - 3'h1);

  // ----------------------------------------
  // Three-stage pin samplers
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      int_sync <= 3'h0;
      nmi_sync <= 3'h0;
      brq_sync <= 3'h0;
      int_q    <= 1'b0;
      nmi_q    <= 1'b0;
      brq_q    <= 1'b0;
      nmi_prev <= 1'b0;
    end else begin
      int_sync <= {int_sync[1:0], ~maskable_request_n};
      nmi_sync <= {nmi_sync[1:0], ~nonmaskable_request_n};
      brq_sync <= {brq_sync[1:0], ~bus_request_n};
      if (int_sync[1] == int_sync[2]) int_q <= int_sync[2];
      if (nmi_sync[1] == nmi_sync[2]) nmi_q <= nmi_sync[2];
      if (brq_sync[1] == brq_sync[2]) brq_q <= brq_sync[2];
      nmi_prev <= nmi_q;
    end
  end

  // ----------------------------------------
  // APB read mux
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata <= 32'h0;
        if (paddr == `DCI_OFF_CTRL)
          prdata <= {30'h0, int_mode};
        else if (paddr == `DCI_OFF_CMD)
          prdata <= 32'h0;
        else if (paddr == `DCI_OFF_STATUS)
          prdata <= {24'h0, state, halted, iff_save, int_enable, nmi_seen};
        else if (paddr == `DCI_OFF_ACC)
          prdata <= {24'h0, acc};
        else if (paddr == `DCI_OFF_VBASE)
          prdata <= {24'h0, vector_base_reg};
        else if (paddr == `DCI_OFF_PC)
          prdata <= {16'h0, pc};
        else if (paddr == `DCI_OFF_TABLE)
          prdata <= {16'h0, table_ptr};
        else if (paddr == `DCI_OFF_FETCH)
          prdata <= {16'h0, extra_bytes, fetched};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Bus cycle generator
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      state                <= ST_IDLE;
      tcnt                 <= 3'h0;
      int_mode             <= `DCI_MODE_RST;
      int_enable           <= 1'b0;
      iff_save             <= 1'b0;
      vector_base_reg      <= `DCI_VBASE_RST;
      acc                  <= 8'h00;
      pc                   <= `DCI_PC_RST;
      sp                   <= `DCI_SP_RST;
      table_ptr            <= 16'h0000;
      fetched              <= 8'h00;
      extra_bytes          <= 8'h00;
      nmi_seen             <= 1'b0;
      ret_req              <= 1'b0;
      return_from_interrupt_op_req             <= 1'b0;
      use_table            <= 1'b0;
      halted               <= 1'b0;
      opcode_fetch_cycle_n <= 1'b1;
      memory_request_n     <= 1'b1;
      io_request_n         <= 1'b1;
      read_strobe_n        <= 1'b1;
      address              <= 16'h0000;
      data_out             <= 8'h00;
      data_out_en_n        <= 1'b1;
    end else begin
      if (nmi_edge) nmi_seen <= 1'b1;
      // Register writes
      if (apb_wr && psel && paddr == `DCI_OFF_CTRL) int_mode <= pwdata[1:0];
      if (apb_wr && paddr == `DCI_OFF_ACC) acc <= pwdata[7:0];
      if (apb_wr && paddr == `DCI_OFF_PC) pc <= pwdata[15:0];
      if (apb_wr && paddr == `DCI_OFF_FETCH) extra_bytes <= pwdata[15:8];
      if (apb_wr && paddr == `DCI_OFF_CMD) begin
        if (pwdata[`DCI_CMD_EI]) int_enable <= 1'b1;
        if (pwdata[`DCI_CMD_DI]) int_enable <= 1'b0;
        if (pwdata[`DCI_CMD_LD_VBASE]) vector_base_reg <= acc;
        if (pwdata[`DCI_CMD_HALT]) halted <= 1'b1;
        if (pwdata[`DCI_CMD_RET]) ret_req <= 1'b1;
        if (pwdata[`DCI_CMD_RETURN_FROM_INTERRUPT_OP]) return_from_interrupt_op_req <= 1'b1;
      end
      tcnt <= (tcnt == `DCI_TMAX) ? 3'h0 : tcnt + 3'h1;
      case (state)
        ST_IDLE, ST_HALT: begin
          opcode_fetch_cycle_n <= ~halted | last_t;
          memory_request_n     <= ~halted | last_t;
          read_strobe_n        <= ~halted | last_t;
          io_request_n         <= 1'b1;
          data_out_en_n        <= 1'b1;
          address              <= pc;
          if (tcnt >= `DCI_T_STATES - 3'h1) begin
            tcnt <= 3'h0;
            // Sample at fourth state
            if (brq_q) begin
              state <= ST_IDLE;
            end else if (nmi_seen) begin
              nmi_seen   <= nmi_edge;
              use_table  <= 1'b0;
              halted     <= 1'b0;
              iff_save   <= int_enable;
              int_enable <= 1'b0;
              table_ptr  <= `DCI_ADDR_NMI;
              state      <= ST_PUSHH;
            end else if (int_q && int_enable) begin
              halted     <= 1'b0;
              int_enable <= 1'b0;
              opcode_fetch_cycle_n <= 1'b0;
              state      <= ST_ACK;
            end else if (return_from_interrupt_op_req) begin
              return_from_interrupt_op_req <= cmd_wr & pwdata[`DCI_CMD_RETURN_FROM_INTERRUPT_OP];
              state    <= ST_RETI0;
            end else if (ret_req) begin
              // Pop the return address through the table reader
              ret_req   <= cmd_wr & pwdata[`DCI_CMD_RET];
              table_ptr <= sp;
              sp        <= sp + 16'h0002;
              state     <= ST_TBL0;
            end
          end
        end
        ST_ACK: begin
          // Fetch with io request, read held off, two waits
          opcode_fetch_cycle_n <= 1'b0;
          memory_request_n     <= 1'b1;
          read_strobe_n        <= 1'b1;
          io_request_n         <= (tcnt < 3'h2);
          if (tcnt == `DCI_T_STATES + `DCI_ACK_WAITS - 3'h1) begin
            fetched              <= data_in;
            tcnt                 <= 3'h0;
            opcode_fetch_cycle_n <= 1'b1;
            io_request_n         <= 1'b1;
            if (int_mode == 2'h0) begin
              state <= (extra_bytes != 8'h00) ? ST_M0RD : ST_PUSHH;
              table_ptr <= {10'h0, data_in[5:3], 3'h0};
              use_table <= 1'b0;
            end else if (int_mode == 2'h1) begin
              table_ptr <= `DCI_ADDR_MODE1;
              use_table <= 1'b0;
              state     <= ST_PUSHH;
            end else begin
              table_ptr <= {vector_base_reg, data_in};
              use_table <= 1'b1;
              state     <= ST_PUSHH;
            end
          end
        end
        ST_M0RD: begin
          // Extra bytes from interrupt hardware, counter held
          memory_request_n <= 1'b0;
          read_strobe_n    <= 1'b0;
          address          <= pc;
          if (last_t) begin
            tcnt        <= 3'h0;
            fetched     <= data_in;
            extra_bytes <= extra_bytes - 8'h01;
            if (extra_bytes == 8'h01) state <= ST_IDLE;
          end
        end
        ST_PUSHH, ST_PUSHL: begin
          memory_request_n <= 1'b0;
          read_strobe_n    <= 1'b1;
          data_out_en_n    <= 1'b0;
          address          <= sp - 16'h0001;
          data_out         <= (state == ST_PUSHH) ? pc[15:8] : pc[7:0];
          if (last_t) begin
            tcnt <= 3'h0;
            sp   <= sp - 16'h0001;
            data_out_en_n <= 1'b1;
            if (state == ST_PUSHH) state <= ST_PUSHL;
            else if (use_table) state <= ST_TBL0;
            else begin
              pc    <= table_ptr;
              state <= ST_IDLE;
            end
          end
        end
        ST_TBL0, ST_TBL1: begin
          memory_request_n <= 1'b0;
          read_strobe_n    <= 1'b0;
          address <= (state == ST_TBL0) ? table_ptr : table_ptr + 16'h0001;
          if (last_t) begin
            tcnt <= 3'h0;
            if (state == ST_TBL0) begin
              pc[7:0] <= data_in;
              state   <= ST_TBL1;
            end else begin
              pc[15:8] <= data_in;
              state    <= ST_IDLE;
            end
          end
        end
        ST_RETI0, ST_RETI1: begin
          // Two-byte return opcode fetched onto the bus
          opcode_fetch_cycle_n <= 1'b0;
          memory_request_n     <= 1'b0;
          read_strobe_n        <= 1'b0;
          data_out_en_n        <= 1'b0;
          data_out <= (state == ST_RETI0) ? `DCI_OP_PREFIX : `DCI_OP_RETI2;
          if (last_t) begin
            tcnt <= 3'h0;
            opcode_fetch_cycle_n <= 1'b1;
            data_out_en_n <= 1'b1;
            if (state == ST_RETI0) state <= ST_RETI1;
            else begin
              // Pop the interrupted counter after the opcode pair
              table_ptr <= sp;
              sp        <= sp + 16'h0002;
              state     <= ST_TBL0;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // dci_core
`default_nettype wire

// [dci_defs.vh]
`ifndef DCI_DEFS_VH
`define DCI_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DCI_OFF_CTRL      12'h000
`define DCI_OFF_CMD       12'h004
`define DCI_OFF_STATUS    12'h008
`define DCI_OFF_ACC       12'h00c
`define DCI_OFF_VBASE     12'h010
`define DCI_OFF_PC        12'h014
`define DCI_OFF_TABLE     12'h018
`define DCI_OFF_FETCH     12'h01c
// ----------------------------------------
// Command bits
// ----------------------------------------
`define DCI_CMD_EI        0
`define DCI_CMD_DI        1
`define DCI_CMD_HALT      2
`define DCI_CMD_LD_VBASE  3
`define DCI_CMD_RET       4
`define DCI_CMD_RETURN_FROM_INTERRUPT_OP      5
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define DCI_MODE_RST      2'h0
`define DCI_VBASE_RST     8'h00
`define DCI_PC_RST        16'h0000
`define DCI_SP_RST        16'hfffe
`define DCI_ADDR_MODE1    16'h0038
`define DCI_ADDR_NMI      16'h0066
`define DCI_OP_PREFIX     8'hed
`define DCI_OP_RETI2      8'h4d
`define DCI_OP_NOP        8'h00
`define DCI_T_STATES      3'h4
`define DCI_ACK_WAITS     3'h2
`define DCI_TMAX          3'h7
`endif

// [dci_core_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module dci_core_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // Register bus
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Bus cycle
  input wire logic       opcode_fetch_cycle_n,
  input wire logic       memory_request_n,
  input wire logic       io_request_n,
  input wire logic       read_strobe_n,
  input wire logic       data_out_en_n,
  // Status
  input wire logic       halted,
  input wire logic       int_enable,
  input wire logic [1:0] int_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire ack = !opcode_fetch_cycle_n && !io_request_n;
  chk_ack_strobes: assert property (ack |-> read_strobe_n && memory_request_n)
    else $error("ack with read strobe");
  chk_reset_state: assert property ($past(srst) |-> int_mode == 2'h0 && !int_enable)
    else $error("bad state after reset");
  chk_ack_masked: assert property (ack |-> !int_enable)
    else $error("enable set during ack");
  chk_disable_cause: assert property ($fell(int_enable) |-> ##[0:16] ack)
    else $error("enable cleared without ack");
  chk_ack_settle: assert property ($fell(io_request_n) |-> !$past(opcode_fetch_cycle_n, 2))
    else $error("io request too early");
  chk_halt_fetch: assert property ($rose(halted) |-> ##[0:8] !opcode_fetch_cycle_n)
    else $error("no fetch in halt");
  chk_halt_exit: assert property ($fell(halted) |-> ##[0:8] ack)
    else $error("halt left without ack");
  chk_ack_bus_free: assert property (!io_request_n |-> data_out_en_n)
    else $error("data driven during ack");
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("late ready");
  cov_ack: cover property ($fell(io_request_n));
  cov_halt: cover property ($fell(halted));
  cov_ret: cover property (!data_out_en_n && !opcode_fetch_cycle_n);
endmodule // dci_core_monitor
bind dci_core dci_core_monitor u_mon (.*);
`default_nettype wire

// [dci_periph_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dci_periph_model (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Bench control
  input wire logic        raise,
  input wire logic [7:0]  vec,
  // Chain
  input wire logic        chain_enable_in,
  output logic            chain_enable_out,
  output logic            maskable_request_n,
  output logic            in_service,
  // Processor bus
  input wire logic        opcode_fetch_cycle_n,
  input wire logic        io_request_n,
  input wire logic        memory_request_n,
  input wire logic        read_strobe_n,
  input wire logic [15:0] address,
  input wire logic [7:0]  data_out,
  input wire logic        data_out_en_n,
  output logic [7:0]      data_in
);
  logic pend;
  logic frozen;
  logic saw_pre;
  assign maskable_request_n = ~(pend & ~in_service & chain_enable_in);
  assign chain_enable_out = chain_enable_in & ~in_service & (~pend | saw_pre);
  always @(posedge ref_clk) begin
    data_in <= ~data_in;
    if (srst) begin
      data_in <= 8'h5a;
      pend <= 1'b0;
      frozen <= 1'b0;
      saw_pre <= 1'b0;
      in_service <= 1'b0;
    end else begin
      if (raise)
        pend <= 1'b1;
      if (opcode_fetch_cycle_n)
        frozen <= pend & chain_enable_in;
      if (!opcode_fetch_cycle_n && !io_request_n && frozen) begin
        data_in <= vec;
        pend <= 1'b0;
        in_service <= 1'b1;
      end
      if (!memory_request_n && !read_strobe_n)
        data_in <= address[7:0] + 8'h01;
      if (!opcode_fetch_cycle_n && !data_out_en_n && data_out == 8'hed)
        saw_pre <= 1'b1;
      if (!opcode_fetch_cycle_n && !data_out_en_n && data_out == 8'h4d && saw_pre) begin
        saw_pre <= 1'b0;
        in_service <= in_service & ~chain_enable_in;
      end
    end
  end
endmodule // dci_periph_model
`default_nettype wire

// [test_daisy_chain_interrupt_response.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dci_defs.vh"
module test_daisy_chain_interrupt_response;
  logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic nonmaskable_request_n = 1'b1, bus_request_n = 1'b1, raise = 1'b0, err;
  logic [7:0] vec = 8'h00;
  wire [31:0] prdata;
  wire [15:0] address;
  wire [7:0] data_out, data_in;
  wire [1:0] int_mode;
  wire pready, pslverr, maskable_request_n, opcode_fetch_cycle_n, memory_request_n;
  wire io_request_n, read_strobe_n, data_out_en_n, halted, int_enable, in_service;
  wire chain_enable_in = 1'b1;
  int fail_count = 0, tests_run = 0;
  dci_core DUT (.*);
  dci_periph_model peer (.*, .chain_enable_out());
  initial forever #2.5 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic give_up(input string nm);
    check(nm, 32'h0, 32'h1);
    close_out();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) give_up("apb timeout");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    check("mode", {30'h0, int_mode}, 32'h0);
    check("enable", {31'h0, int_enable}, 32'h0);
    apb(1'b0, `DCI_OFF_VBASE, 32'h0);
    check("vbase", rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic test_regs();
    apb(1'b1, `DCI_OFF_ACC, 32'h12);
    apb(1'b1, `DCI_OFF_VBASE, 32'h55);
    apb(1'b0, `DCI_OFF_VBASE, 32'h0);
    check("vbase ro", rd, 32'h0);
    apb(1'b1, `DCI_OFF_CMD, 32'h8);
    apb(1'b0, `DCI_OFF_VBASE, 32'h0);
    check("vbase load", rd, 32'h12);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    $display("register test done");
  endtask
  task automatic run_int(input logic [1:0] md, input logic [7:0] v, input logic hlt,
                         input logic [15:0] pc_exp);
    int n;
    logic hit;
    hit = 1'b0;
    apb(1'b1, `DCI_OFF_CTRL, {30'h0, md});
    if (hlt) begin
      apb(1'b1, `DCI_OFF_CMD, 32'h4);
      for (n = 0; n < 8 && halted !== 1'b1; n++) @(posedge ref_clk);
      check("halted", {31'h0, halted}, 32'h1);
    end
    raise <= 1'b1;
    vec <= v;
    @(posedge ref_clk);
    raise <= 1'b0;
    for (n = 0; n < 32; n++) begin
      @(posedge ref_clk);
      hit = hit | (io_request_n === 1'b0);
    end
    check("masked ack", {31'h0, hit}, 32'h0);
    apb(1'b1, `DCI_OFF_CMD, 32'h1);
    for (n = 0; n < 400 && io_request_n !== 1'b0; n++) @(posedge ref_clk);
    if (io_request_n !== 1'b0) give_up("ack timeout");
    check("enable in ack", {31'h0, int_enable}, 32'h0);
    rd = 32'hffffffff;
    for (n = 0; n < 40 && rd !== {16'h0, pc_exp}; n++) apb(1'b0, `DCI_OFF_PC, 32'h0);
    check("pc", rd, {16'h0, pc_exp});
    check("halt left", {31'h0, halted}, 32'h0);
    apb(1'b1, `DCI_OFF_CMD, 32'h20);
    for (n = 0; n < 400 && in_service !== 1'b0; n++) @(posedge ref_clk);
    check("service end", {31'h0, in_service}, 32'h0);
    $display("interrupt test mode %0d done", md);
  endtask
  task automatic test_more();
    int n;
    logic hit;
    hit = 1'b0;
    repeat (16) @(posedge ref_clk);
    bus_request_n <= 1'b0;
    apb(1'b1, `DCI_OFF_CTRL, 32'h0);
    apb(1'b1, `DCI_OFF_FETCH, 32'h200);
    apb(1'b1, `DCI_OFF_PC, 32'h1234);
    raise <= 1'b1;
    vec <= 8'hff;
    @(posedge ref_clk);
    raise <= 1'b0;
    apb(1'b1, `DCI_OFF_CMD, 32'h1);
    for (n = 0; n < 32; n++) begin
      @(posedge ref_clk);
      hit = hit | (io_request_n === 1'b0);
    end
    check("bus held", {31'h0, hit}, 32'h0);
    bus_request_n <= 1'b1;
    for (n = 0; n < 400 && io_request_n !== 1'b0; n++) @(posedge ref_clk);
    if (io_request_n !== 1'b0) give_up("ack timeout");
    rd = 32'hffffffff;
    for (n = 0; n < 40 && rd !== 32'h35; n++) apb(1'b0, `DCI_OFF_FETCH, 32'h0);
    check("extra bytes", rd, 32'h35);
    apb(1'b0, `DCI_OFF_PC, 32'h0);
    check("pc held", rd, 32'h1234);
    apb(1'b1, `DCI_OFF_CMD, 32'h20);
    rd = 32'hffffffff;
    for (n = 0; n < 40 && rd !== 32'hff; n++) apb(1'b0, `DCI_OFF_PC, 32'h0);
    check("return_from_interrupt_op pop", rd, 32'hff);
    check("service end", {31'h0, in_service}, 32'h0);
    apb(1'b1, `DCI_OFF_CMD, 32'h10);
    rd = 32'hffffffff;
    for (n = 0; n < 40 && rd !== 32'h201; n++) apb(1'b0, `DCI_OFF_PC, 32'h0);
    check("ret pop", rd, 32'h201);
    nonmaskable_request_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    nonmaskable_request_n <= 1'b1;
    rd = 32'hffffffff;
    for (n = 0; n < 40 && rd !== 32'h66; n++) apb(1'b0, `DCI_OFF_PC, 32'h0);
    check("nmi entry", rd, 32'h66);
    $display("extra paths test done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    test_reset();
    test_regs();
    run_int(2'h1, 8'h00, 1'b0, 16'h0038);
    run_int(2'h0, 8'hd7, 1'b1, 16'h0010);
    run_int(2'h2, 8'h40, 1'b0, 16'h4241);
    test_more();
    close_out();
  end
endmodule // test_daisy_chain_interrupt_response
`default_nettype wire
